// File: sim/tb_top.sv
/* testbench for the touch key block with the host model.
   assumes shortened timer parameters; keys 1..11 sit at 0x064. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic        sys_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        smp_p = 1'b0;
  logic [11:0] s0 = 12'h064;
  logic [5:0]  addr;
  logic [7:0]  wdat, rdat;
  logic        wr, rd, nack, oen;
  logic [11:0] touch;
  logic        crst, chg;
  logic        stt = 1'b0;
  logic [7:0]  acq;
  int          n_crst = 0;
  wire [143:0] sig = {{11{12'h064}}, s0};
  int          n_fail = 0;
  int          checks_done = 0;
  logic [5:0]  ra [8] = '{6'h05, 6'h06, 6'h07, 6'h08, 6'h09, 6'h0A,
                          6'h20, 6'h3F};
  logic [7:0]  rv [8] = '{8'h01, 8'h14, 8'h05, 8'h04, 8'hBC, 8'h19,
                          8'h0A, 8'h00};
  // 25 MHz clock
  always #20 sys_clk_i = ~sys_clk_i;
  tkd_top #(.TICK_CYC(20), .WDOG_CYC(30), .REFUSE_CYC(50), .ALERT_CYC(10))
    u_tkd_top (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .ce_i(1'b1),
    .addr_i(addr), .wr_data_i(wdat), .wr_i(wr), .rd_i(rd),
    .rd_data_o(rdat), .bus_nack_o(nack), .standalone_i(1'b0),
    .acq_start_i(stt), .sample_i(smp_p), .sig_i(sig),
    .key_touch_o(touch), .acq_interval_o(acq), .charge_o(chg),
    .chip_reset_o(crst), .alert_o(), .alert_oen_o(oen));
  // count full-reset pulses from the watchdog
  always @(posedge sys_clk_i)
    if (crst === 1'b1)
      n_crst <= n_crst + 1;
  tkd_host u_tkd_host (.clk_i(sys_clk_i), .rd_data_i(rdat),
    .alert_oen_i(oen), .nack_i(nack), .addr_o(addr), .wr_data_o(wdat),
    .wr_o(wr), .rd_o(rd));
  task automatic chk(input string nm, input logic [11:0] e, g);
    checks_done++;
    if (g !== e)
    begin
      n_fail++;
      $display("ERROR %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rc(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] v;
    u_tkd_host.rd(a, v);
    chk($sformatf("reg %h", a), {4'h0, e}, {4'h0, v});
  endtask
  // n samples of key 0, then time for detect to reach the port
  task automatic smp(input logic [11:0] v, input int n);
    repeat (n)
    begin
      @(posedge sys_clk_i);
      s0 <= v;
      smp_p <= 1'b1;
      @(posedge sys_clk_i);
      smp_p <= 1'b0;
    end
    repeat (3) @(posedge sys_clk_i);
  endtask
  task automatic t_boot();
    u_tkd_host.wait_ready();
    chk("alert low", 12'h000, {11'h0, oen});
    rc(6'h00, 8'h00);
    repeat (2) @(posedge sys_clk_i);
    chk("alert freed", 12'h001, {11'h0, oen});
    for (int i = 0; i < 8; i++)
      rc(ra[i], rv[i]);
    $display("boot done");
  endtask
  // interval 3 must be overridden while calibrating
  task automatic t_cal();
    u_tkd_host.wr(6'h05, 8'h03);
    u_tkd_host.wr(6'h04, 8'h01);
    rc(6'h00, 8'h80);
    chk("fast in cal", 12'h001, {4'h0, acq});
    smp(12'h064, 14);
    rc(6'h00, 8'h80);
    smp(12'h064, 1);
    rc(6'h00, 8'h00);
    chk("slow after cal", 12'h003, {4'h0, acq});
    $display("cal done");
  endtask
  task automatic t_touch();
    u_tkd_host.wr(6'h08, 8'h00);
    smp(12'h06E, 2);
    chk("at limit", 12'h000, touch);
    smp(12'h06F, 1);
    chk("over limit", 12'h001, touch);
    rc(6'h01, 8'h01);
    smp(12'h06D, 1);
    chk("hysteresis", 12'h001, touch);
    smp(12'h06C, 1);
    chk("release", 12'h000, touch);
    $display("touch done");
  endtask
  task automatic t_conf();
    u_tkd_host.wr(6'h08, 8'h03);
    smp(12'h06F, 2);
    smp(12'h064, 1);
    smp(12'h06F, 2);
    chk("broken run", 12'h000, touch);
    smp(12'h06F, 1);
    chk("full run", 12'h001, touch);
    smp(12'h064, 2);
    chk("early release", 12'h001, touch);
    smp(12'h064, 1);
    chk("released", 12'h000, touch);
    u_tkd_host.wr(6'h08, 8'h21);
    smp(12'h06F, 4);
    chk("over 32", 12'h000, touch);
    u_tkd_host.wr(6'h08, 8'h01);
    $display("confirm done");
  endtask
  // a negative jump re-bases key 0, making a small rise a touch
  task automatic t_away();
    smp(12'h05F, 1);
    smp(12'h06A, 1);
    chk("re-based", 12'h001, touch);
    smp(12'h05F, 1);
    u_tkd_host.wr(6'h09, 8'h01);
    smp(12'h06F, 1);
    repeat (60) @(posedge sys_clk_i);
    smp(12'h06F, 1);
    chk("stuck", 12'h000, touch);
    smp(12'h064, 1);
    u_tkd_host.wr(6'h10, 8'h01);
    u_tkd_host.wr(6'h04, 8'h01);
    smp(12'h064, 15);
    smp(12'h06F, 1);
    chk("as output", 12'h000, touch);
    u_tkd_host.wr(6'h10, 8'h00);
    u_tkd_host.wr(6'h04, 8'h01);
    smp(12'h064, 15);
    $display("recal done");
  endtask
  // charge pulse at setting 2: three microseconds of 25 cycles each
  task automatic t_chg();
    int n;
    u_tkd_host.wr(6'h0B, 8'h02);
    @(posedge sys_clk_i);
    stt <= 1'b1;
    @(posedge sys_clk_i);
    stt <= 1'b0;
    n = 0;
    @(posedge sys_clk_i);
    while (chg === 1'b1 && n < 200)
    begin
      n++;
      @(posedge sys_clk_i);
    end
    chk("charge", 12'h04B, n[11:0]);
    $display("charge done");
  endtask
  // status read first frees the alert, so its fall marks the reboot
  task automatic t_soft();
    rc(6'h00, 8'h00);
    u_tkd_host.wr(6'h05, 8'h03);
    u_tkd_host.wr(6'h03, 8'h01);
    rc(6'h05, 8'h00);
    chk("refusing", 12'h001, {11'h0, nack});
    chk("no early reset", 12'h000, n_crst[11:0]);
    u_tkd_host.wait_ready();
    chk("reset pulse", 12'h001, n_crst[11:0]);
    rc(6'h05, 8'h01);
    $display("soft reset done");
  endtask
  task automatic results();
    $display("checks %0d fails %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // hang guard: the scenarios need well under 5000 cycles
  initial
  begin
    #200000;
    n_fail++;
    results();
  end
  // reset for two cycles, then the scenarios
  initial
  begin
    repeat (2) @(posedge sys_clk_i);
    rst_i <= 1'b0;
    t_boot();
    t_cal();
    t_touch();
    t_conf();
    t_away();
    t_chg();
    t_soft();
    results();
  end
endmodule
`default_nettype wire

// File: sim/tkd_chk_chk.sv
/* port checker for the touch key block.
   assumes it is bound into tkd_top with its key count. */
`timescale 1ns/1ps
`default_nettype none
module tkd_chk #(
  parameter NKEY = 12
) (
  input wire logic            sys_clk_i,
  input wire logic            rst_i,
  input wire logic [5:0]      addr_i,
  input wire logic [7:0]      wr_data_i,
  input wire logic            wr_i,
  input wire logic            rd_i,
  input wire logic [7:0]      rd_data_o,
  input wire logic            bus_nack_o,
  input wire logic [NKEY-1:0] key_touch_o,
  input wire logic [7:0]      acq_interval_o,
  input wire logic            chip_reset_o,
  input wire logic            alert_o,
  input wire logic            alert_oen_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // soft reset write opens a refusal window and a watchdog
  a_nack_rise:
    assert property (wr_i && addr_i == 6'h03 && wr_data_i != 8'h00 &&
      !bus_nack_o |=> bus_nack_o) else $error("no refusal");
  a_nack_hold:
    assert property ($rose(bus_nack_o) |-> bus_nack_o[*8])
      else $error("refusal too short");
  a_wdog_time:
    assert property ($rose(bus_nack_o) |-> !chip_reset_o[*8]
      ##[16:26] chip_reset_o) else $error("watchdog timing");
  a_nack_read:
    assert property (bus_nack_o && rd_i |=> rd_data_o == 8'h00)
      else $error("read served while refusing");
  // alert pin is open drain and falls a fixed time after reset
  a_alert_open:
    assert property (alert_o == 1'b0) else $error("alert driven high");
  a_alert_boot:
    assert property ($fell(rst_i) |-> alert_oen_o[*8] ##[1:5] !alert_oen_o)
      else $error("alert timing");
  // fast interval forced by touch and calibration
  a_touch_fast:
    assert property (key_touch_o != 0 |-> acq_interval_o == 8'h01)
      else $error("slow interval in touch");
  a_cal_fast:
    assert property (wr_i && addr_i == 6'h04 && wr_data_i != 8'h00 &&
      !bus_nack_o |-> ##2 acq_interval_o == 8'h01)
      else $error("slow interval in calibration");
endmodule
bind tkd_top tkd_chk #(.NKEY(NKEY)) u_tkd_chk (.sys_clk_i(sys_clk_i),
  .rst_i(rst_i), .addr_i(addr_i), .wr_data_i(wr_data_i), .wr_i(wr_i),
  .rd_i(rd_i), .rd_data_o(rd_data_o), .bus_nack_o(bus_nack_o),
  .key_touch_o(key_touch_o), .acq_interval_o(acq_interval_o),
  .chip_reset_o(chip_reset_o), .alert_o(alert_o),
  .alert_oen_o(alert_oen_o));
`default_nettype wire

// File: sim/tkd_host.sv
/* host model: master on the register port of the touch key block.
   assumes one-cycle strobes and read data in the next cycle only. */
`timescale 1ns/1ps
`default_nettype none
module tkd_host (
  input  wire logic       clk_i,
  input  wire logic [7:0] rd_data_i,
  input  wire logic       alert_oen_i,
  input  wire logic       nack_i,
  output var  logic [5:0] addr_o,
  output var  logic [7:0] wr_data_o,
  output var  logic       wr_o,
  output var  logic       rd_o
);
  // bus idle from time zero
  initial
  begin
    addr_o = 6'h00;
    wr_data_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one write cycle; strobe drops at the edge that takes it
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    @(posedge clk_i);
    addr_o <= a;
    wr_data_o <= v;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
  endtask
  // read data is only valid at the edge after the strobe
  task automatic rd(input logic [5:0] a, output logic [7:0] v);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    @(posedge clk_i);
    v = rd_data_i;
  endtask
  // after soft reset stay off the bus until alert falls, then until
  // refusal lapses, since the two spans are not tied to each other
  task automatic wait_ready();
    repeat (200) if (alert_oen_i !== 1'b0) @(posedge clk_i);
    repeat (200) if (nack_i !== 1'b0) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// File: verilog/tkd_key.v
/*
  one touch key: delta against reference, confirm integrator with
  hysteresis, reference drift, stuck and away-from-touch recalibration.
  assumes sample strobes and ticks are one-cycle pulses on sys_clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
`include "tkd_regs.vh"

module tkd_key #(
  parameter SW = 12
) (
  input  wire          sys_clk_i,
  input  wire          rst_i,
  input  wire          ce_i,
  input  wire          clr_i,
  input  wire          sample_i,
  input  wire          tick_i,
  input  wire [SW-1:0] sig_i,
  input  wire [7:0]    thr_i,
  input  wire [7:0]    confirm_i,
  input  wire [7:0]    stuck_i,
  input  wire          cal_i,
  input  wire          drift_in_i,
  input  wire          drift_out_i,
  input  wire          freeze_i,
  input  wire          block_i,
  output reg           detect_o,
  output wire          pending_o
);

  reg [SW-1:0] ref_reg;
  reg [7:0]    cnt_reg;
  reg [7:0]    stuck_reg;
  reg          recal_reg;

  wire signed [SW:0] delta = $signed({1'b0, sig_i}) - $signed({1'b0, ref_reg});
  wire [7:0] hys_raw = {3'h0, thr_i[7:3]};
  wire [7:0] neg_raw = {2'h0, thr_i[7:2]};
  wire [7:0] hys   = (hys_raw < `TKD_HYS_MIN) ? `TKD_HYS_MIN : hys_raw;
  wire [7:0] neg_m = (neg_raw < `TKD_NEG_MIN) ? `TKD_NEG_MIN : neg_raw;
  wire [7:0] rel_thr = (thr_i > hys) ? thr_i - hys : 8'h00;
  wire signed [SW:0] thr_s = $signed({{(SW-7){1'b0}}, thr_i});
  wire signed [SW:0] rel_s = $signed({{(SW-7){1'b0}}, rel_thr});
  wire signed [SW:0] neg_s = -$signed({{(SW-7){1'b0}}, neg_m});
  wire over     = delta > thr_s;
  wire stay     = delta > rel_s;
  wire neg_jump = delta < neg_s;
  wire [7:0] need = (confirm_i == 8'h00) ? 8'h01 : confirm_i;
  wire never    = confirm_i > `TKD_CONFIRM_MAX;
  wire [7:0] cnt_inc = cnt_reg + 8'h01;

  assign pending_o = cnt_reg != 8'h00;

  // stuck timer counts ticks in detect; request set wins over its clear
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      stuck_reg <= 8'h00;
      recal_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (clr_i || !detect_o)
        stuck_reg <= 8'h00;
      else if (tick_i && stuck_reg != 8'hFF)
        stuck_reg <= stuck_reg + 8'h01;
      if (clr_i)
        recal_reg <= 1'b0;
      else if (detect_o && stuck_i != 8'h00 && stuck_reg >= stuck_i)
        recal_reg <= 1'b1;
      else if (sample_i)
        recal_reg <= 1'b0;
    end

  // per-acquisition update of reference and detect state
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      ref_reg  <= {SW{1'b0}};
      cnt_reg  <= 8'h00;
      detect_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (clr_i)
      begin
        ref_reg  <= {SW{1'b0}};
        cnt_reg  <= 8'h00;
        detect_o <= 1'b0;
      end
      else if (sample_i)
      begin
        if (cal_i || recal_reg || neg_jump)
        begin
          ref_reg  <= sig_i;
          cnt_reg  <= 8'h00;
          detect_o <= 1'b0;
        end
        else if (!detect_o)
        begin
          if (over && !block_i && !never)
          begin
            cnt_reg  <= (cnt_inc >= need) ? 8'h00 : cnt_inc;
            detect_o <= cnt_inc >= need;
          end
          else
            cnt_reg <= 8'h00;
          // drift only outside detect and outside the freeze window
          if (!freeze_i && drift_in_i && delta > 0)
            ref_reg <= ref_reg + {{(SW-1){1'b0}}, 1'b1};
          else if (!freeze_i && drift_out_i && delta < 0)
            ref_reg <= ref_reg - {{(SW-1){1'b0}}, 1'b1};
        end
        else if (!stay)
        begin
          cnt_reg  <= (cnt_inc >= need) ? 8'h00 : cnt_inc;
          detect_o <= cnt_inc < need;
        end
        else
          cnt_reg <= 8'h00;
      end
    end

endmodule
`default_nettype wire

// File: verilog/tkd_regs.vh
/*
  register offsets, reset values, fixed standalone settings and timing
  figures of the touch key detection block.
  assumes inclusion by bare name from the block's verilog files.
*/
`ifndef TKD_REGS_VH
`define TKD_REGS_VH

// register offsets (byte index on the 6-bit register port)
`define TKD_A_STATUS    6'h00
`define TKD_A_KEYS_LO   6'h01
`define TKD_A_KEYS_HI   6'h02
`define TKD_A_RESET     6'h03
`define TKD_A_CAL       6'h04
`define TKD_A_ACQ       6'h05
`define TKD_A_DRIFT_IN  6'h06
`define TKD_A_DRIFT_OUT 6'h07
`define TKD_A_CONFIRM   6'h08
`define TKD_A_STUCK     6'h09
`define TKD_A_FREEZE    6'h0A
`define TKD_A_CHARGE    6'h0B
`define TKD_A_CTRL0     6'h10
`define TKD_A_THR0      6'h20

// field positions
`define TKD_B_ANY_DET   0
`define TKD_B_REFUSE    6
`define TKD_B_CAL       7
`define TKD_B_AS_OUT    0
`define TKD_B_GUARD     4

// reset values
`define TKD_R_ACQ       8'h01
`define TKD_R_DRIFT_IN  8'h14
`define TKD_R_DRIFT_OUT 8'h05
`define TKD_R_CONFIRM   8'h04
`define TKD_R_STUCK     8'hBC
`define TKD_R_FREEZE    8'h19
`define TKD_R_CHARGE    8'h00
`define TKD_R_THR       8'h0A
`define TKD_R_CTRL      8'h00

// fixed standalone settings
`define TKD_SA_THR      8'h0A
`define TKD_SA_DRIFT_IN 8'h14
`define TKD_SA_DRIFT_OUT 8'h05
`define TKD_SA_STUCK    8'hBC
`define TKD_SA_GUARD_KEY 1

// detection figures
`define TKD_CAL_BURSTS  4'hF
`define TKD_CONFIRM_MAX 8'h20
`define TKD_HYS_MIN     8'h02
`define TKD_NEG_MIN     8'h04

// timing figures and the clock rate
`define TKD_CLK_KHZ     25000
`define TKD_T_TICK_MS   160
`define TKD_T_WDOG_MS   125
`define TKD_T_REFUSE_MS 200
`define TKD_T_ALERT_MS  85
`define TKD_T_CHARGE_US 1

`endif

// File: verilog/tkd_top.v
/*
  touch key detection core: register port, soft reset watchdog, bus
  refusal window, calibration sequencer, drift timing, hold window,
  acquisition interval selection, charge pulse and status alert.
  assumes samples and acquisition starts arrive from logic on sys_clk_i;
  the standalone strap arrives from a pin.
*/
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "tkd_regs.vh"

module tkd_top #(
  parameter NKEY       = 12,
  parameter SW         = 12,
  parameter TICK_CYC   = `TKD_T_TICK_MS * `TKD_CLK_KHZ,
  parameter WDOG_CYC   = `TKD_T_WDOG_MS * `TKD_CLK_KHZ,
  parameter REFUSE_CYC = `TKD_T_REFUSE_MS * `TKD_CLK_KHZ,
  parameter ALERT_CYC  = `TKD_T_ALERT_MS * `TKD_CLK_KHZ
) (
  input  wire             sys_clk_i,
  input  wire             rst_i,
  input  wire             ce_i,
  input  wire [5:0]       addr_i,
  input  wire [7:0]       wr_data_i,
  input  wire             wr_i,
  input  wire             rd_i,
  output reg  [7:0]       rd_data_o,
  output reg              bus_nack_o,
  input  wire             standalone_i,
  input  wire             acq_start_i,
  input  wire             sample_i,
  input  wire [NKEY*SW-1:0] sig_i,
  output reg  [NKEY-1:0]  key_touch_o,
  output reg  [7:0]       acq_interval_o,
  output reg              charge_o,
  output reg              chip_reset_o,
  output reg              alert_o,
  output reg              alert_oen_o
);

  localparam US_CYC = `TKD_CLK_KHZ / 1000;
  localparam CHG_US_CYC = `TKD_T_CHARGE_US * US_CYC;

  reg  [1:0]  sa_sync_reg;
  reg  [7:0]  acq_reg, din_reg, dout_reg, conf_reg, stuck_reg;
  reg  [7:0]  frz_reg, chg_reg;
  reg  [NKEY*8-1:0] thr_reg, ctrl_reg;
  reg  [31:0] tick_cnt_reg, wdog_reg, refuse_reg, alert_cnt_reg;
  reg         wdog_run_reg, booted_reg, srst_reg;
  reg  [3:0]  cal_cnt_reg;
  reg         cal_reg;
  reg  [7:0]  din_cnt_reg, dout_cnt_reg, hold_reg;
  reg         din_pend_reg, dout_pend_reg;
  reg  [15:0] chg_cnt_reg;
  reg  [NKEY-1:0] seen_reg;

  wire [NKEY-1:0] det, pend, guard, blk;
  wire sa       = sa_sync_reg[1];
  wire tick     = tick_cnt_reg == TICK_CYC - 1;
  wire refusing = refuse_reg != 32'h0;
  wire wr_ok    = wr_i && !refusing;
  wire rd_ok    = rd_i && !refusing;
  wire any_det  = |det;
  wire freeze   = any_det || hold_reg != 8'h00;
  wire guard_det = |(det & guard);
  wire [7:0] rate_in  = sa ? `TKD_SA_DRIFT_IN  : din_reg;
  wire [7:0] rate_out = sa ? `TKD_SA_DRIFT_OUT : dout_reg;
  wire [7:0] stuck_eff = sa ? `TKD_SA_STUCK : stuck_reg;
  wire [15:0] key_stat = {{(16-NKEY){1'b0}}, det};

  // level from a pin: two flops before use
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      sa_sync_reg <= 2'b00;
    else if (ce_i)
      sa_sync_reg <= {sa_sync_reg[0], standalone_i};

  // configuration writes; soft reset returns them to defaults
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      acq_reg   <= `TKD_R_ACQ;
      din_reg   <= `TKD_R_DRIFT_IN;
      dout_reg  <= `TKD_R_DRIFT_OUT;
      conf_reg  <= `TKD_R_CONFIRM;
      stuck_reg <= `TKD_R_STUCK;
      frz_reg   <= `TKD_R_FREEZE;
      chg_reg   <= `TKD_R_CHARGE;
      thr_reg   <= {NKEY{`TKD_R_THR}};
      ctrl_reg  <= {NKEY{`TKD_R_CTRL}};
    end
    else if (ce_i)
    begin
      if (srst_reg)
      begin
        acq_reg   <= `TKD_R_ACQ;
        din_reg   <= `TKD_R_DRIFT_IN;
        dout_reg  <= `TKD_R_DRIFT_OUT;
        conf_reg  <= `TKD_R_CONFIRM;
        stuck_reg <= `TKD_R_STUCK;
        frz_reg   <= `TKD_R_FREEZE;
        chg_reg   <= `TKD_R_CHARGE;
        thr_reg   <= {NKEY{`TKD_R_THR}};
        ctrl_reg  <= {NKEY{`TKD_R_CTRL}};
      end
      else if (wr_ok)
      begin
        case (addr_i)
          `TKD_A_ACQ:       acq_reg   <= wr_data_i;
          `TKD_A_DRIFT_IN:  din_reg   <= wr_data_i;
          `TKD_A_DRIFT_OUT: dout_reg  <= wr_data_i;
          `TKD_A_CONFIRM:   conf_reg  <= wr_data_i;
          `TKD_A_STUCK:     stuck_reg <= wr_data_i;
          `TKD_A_FREEZE:    frz_reg   <= wr_data_i;
          `TKD_A_CHARGE:    chg_reg   <= wr_data_i;
          default:
          begin
            if (addr_i >= `TKD_A_CTRL0 && addr_i < `TKD_A_CTRL0 + NKEY)
              ctrl_reg[(addr_i - `TKD_A_CTRL0)*8 +: 8] <= wr_data_i;
            if (addr_i >= `TKD_A_THR0 && addr_i < `TKD_A_THR0 + NKEY)
              thr_reg[(addr_i - `TKD_A_THR0)*8 +: 8] <= wr_data_i;
          end
        endcase
      end
    end

  // soft reset: watchdog, then a one-cycle internal full reset pulse;
  // not gated by the interval so power-down cannot block it
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      wdog_run_reg <= 1'b0;
      wdog_reg     <= 32'h0;
      srst_reg     <= 1'b0;
      chip_reset_o <= 1'b0;
    end
    else if (ce_i)
    begin
      srst_reg     <= 1'b0;
      chip_reset_o <= 1'b0;
      if (wr_ok && addr_i == `TKD_A_RESET && wr_data_i != 8'h00)
      begin
        wdog_run_reg <= 1'b1;
        wdog_reg     <= 32'h0;
      end
      else if (wdog_run_reg)
      begin
        wdog_reg <= wdog_reg + 32'h1;
        if (wdog_reg == WDOG_CYC - 1)
        begin
          wdog_run_reg <= 1'b0;
          srst_reg     <= 1'b1;
          chip_reset_o <= 1'b1;
        end
      end
    end

  // refusal window survives the internal reset on purpose; nack follows
  // the counter's next value so it never stands over an accepted access
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      refuse_reg <= 32'h0;
      bus_nack_o <= 1'b0;
    end
    else if (ce_i)
    begin
      if (wr_ok && addr_i == `TKD_A_RESET && wr_data_i != 8'h00)
        refuse_reg <= REFUSE_CYC;
      else if (refusing)
        refuse_reg <= refuse_reg - 32'h1;
      bus_nack_o <= (refuse_reg > 32'h1) ||
        (wr_ok && addr_i == `TKD_A_RESET && wr_data_i != 8'h00);
    end

  // read data in the cycle after the strobe only; refused reads give zero
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      rd_data_o <= 8'h00;
    else if (ce_i)
    begin
      rd_data_o <= 8'h00;
      if (rd_ok)
        case (addr_i)
          `TKD_A_STATUS:    rd_data_o <= {cal_reg, refusing, 5'h00, any_det};
          `TKD_A_KEYS_LO:   rd_data_o <= key_stat[7:0];
          `TKD_A_KEYS_HI:   rd_data_o <= key_stat[15:8];
          `TKD_A_ACQ:       rd_data_o <= acq_reg;
          `TKD_A_DRIFT_IN:  rd_data_o <= din_reg;
          `TKD_A_DRIFT_OUT: rd_data_o <= dout_reg;
          `TKD_A_CONFIRM:   rd_data_o <= conf_reg;
          `TKD_A_STUCK:     rd_data_o <= stuck_reg;
          `TKD_A_FREEZE:    rd_data_o <= frz_reg;
          `TKD_A_CHARGE:    rd_data_o <= chg_reg;
          default:
          begin
            if (addr_i >= `TKD_A_CTRL0 && addr_i < `TKD_A_CTRL0 + NKEY)
              rd_data_o <= ctrl_reg[(addr_i - `TKD_A_CTRL0)*8 +: 8];
            if (addr_i >= `TKD_A_THR0 && addr_i < `TKD_A_THR0 + NKEY)
              rd_data_o <= thr_reg[(addr_i - `TKD_A_THR0)*8 +: 8];
          end
        endcase
    end

  // common 160 ms tick for the drift, hold and stuck timers
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
      tick_cnt_reg <= 32'h0;
    else if (ce_i)
      tick_cnt_reg <= (srst_reg || tick) ? 32'h0 : tick_cnt_reg + 32'h1;

  // calibration sequencer: counts acquisitions, flag held throughout
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      cal_reg     <= 1'b0;
      cal_cnt_reg <= 4'h0;
    end
    else if (ce_i)
    begin
      if (srst_reg)
      begin
        cal_reg     <= 1'b1;
        cal_cnt_reg <= 4'h0;
      end
      else if (wr_ok && addr_i == `TKD_A_CAL && wr_data_i != 8'h00)
      begin
        cal_reg     <= 1'b1;
        cal_cnt_reg <= 4'h0;
      end
      else if (cal_reg && sample_i)
      begin
        cal_cnt_reg <= cal_cnt_reg + 4'h1;
        if (cal_cnt_reg == `TKD_CAL_BURSTS - 4'h1)
          cal_reg <= 1'b0;
      end
    end

  // drift step timers and hold window; steps wait for the next sample
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      din_cnt_reg   <= 8'h00;
      dout_cnt_reg  <= 8'h00;
      din_pend_reg  <= 1'b0;
      dout_pend_reg <= 1'b0;
      hold_reg      <= 8'h00;
    end
    else if (ce_i)
    begin
      if (srst_reg || freeze)
      begin
        din_cnt_reg   <= 8'h00;
        dout_cnt_reg  <= 8'h00;
        din_pend_reg  <= 1'b0;
        dout_pend_reg <= 1'b0;
      end
      else
      begin
        if (tick)
        begin
          din_cnt_reg  <= (din_cnt_reg + 8'h01 >= rate_in) ? 8'h00
                          : din_cnt_reg + 8'h01;
          dout_cnt_reg <= (dout_cnt_reg + 8'h01 >= rate_out) ? 8'h00
                          : dout_cnt_reg + 8'h01;
        end
        if (tick && rate_in != 8'h00 && din_cnt_reg + 8'h01 >= rate_in)
          din_pend_reg <= 1'b1;
        else if (sample_i)
          din_pend_reg <= 1'b0;
        if (tick && rate_out != 8'h00 && dout_cnt_reg + 8'h01 >= rate_out)
          dout_pend_reg <= 1'b1;
        else if (sample_i)
          dout_pend_reg <= 1'b0;
      end
      // standalone keeps the default hold time
      if (srst_reg)
        hold_reg <= 8'h00;
      else if (any_det)
        hold_reg <= sa ? `TKD_R_FREEZE : frz_reg;
      else if (tick && hold_reg != 8'h00)
        hold_reg <= hold_reg - 8'h01;
    end

  // guard selection and blocking of non-guard keys
  genvar k;
  generate
    for (k = 0; k < NKEY; k = k + 1)
    begin : g_key
      assign guard[k] = sa ? (k == `TKD_SA_GUARD_KEY)
                           : ctrl_reg[k*8 + `TKD_B_GUARD];
      assign blk[k] = (!sa && ctrl_reg[k*8 + `TKD_B_AS_OUT]) ||
                      (guard_det && !guard[k]);
      tkd_key #(
        .SW (SW)
      ) u_key (
        .sys_clk_i   (sys_clk_i),
        .rst_i       (rst_i),
        .ce_i        (ce_i),
        .clr_i       (srst_reg),
        .sample_i    (sample_i),
        .tick_i      (tick),
        .sig_i       (sig_i[k*SW +: SW]),
        .thr_i       (sa ? `TKD_SA_THR : thr_reg[k*8 +: 8]),
        .confirm_i   (conf_reg),
        .stuck_i     (stuck_eff),
        .cal_i       (cal_reg),
        .drift_in_i  (din_pend_reg),
        .drift_out_i (dout_pend_reg),
        .freeze_i    (freeze),
        .block_i     (blk[k]),
        .detect_o    (det[k]),
        .pending_o   (pend[k])
      );
    end
  endgenerate

  // effective acquisition interval and key outputs
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      acq_interval_o <= `TKD_R_ACQ;
      key_touch_o    <= {NKEY{1'b0}};
    end
    else if (ce_i)
    begin
      acq_interval_o <= (cal_reg || freeze || |pend) ? 8'h01
                        : acq_reg;
      key_touch_o    <= det;
    end

  // charge pulse: one base microsecond plus one per setting step
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      chg_cnt_reg <= 16'h0;
      charge_o    <= 1'b0;
    end
    else if (ce_i)
    begin
      if (acq_start_i && !charge_o)
      begin
        chg_cnt_reg <= 16'h0;
        charge_o    <= 1'b1;
      end
      else if (charge_o)
      begin
        chg_cnt_reg <= chg_cnt_reg + 16'h1;
        if (chg_cnt_reg == (({8'h00, chg_reg} + 16'h1) *
            CHG_US_CYC[15:0]) - 16'h1)
          charge_o <= 1'b0;
      end
    end

  // alert: low after boot delay, low again on status change, released
  // by a status read; a change in the read cycle keeps it low
  always @(posedge sys_clk_i or posedge rst_i)
    if (rst_i)
    begin
      alert_cnt_reg <= 32'h0;
      booted_reg    <= 1'b0;
      alert_oen_o   <= 1'b1;
      alert_o       <= 1'b0;
      seen_reg      <= {NKEY{1'b0}};
    end
    else if (ce_i)
    begin
      alert_o <= 1'b0;
      if (srst_reg)
      begin
        alert_cnt_reg <= 32'h0;
        booted_reg    <= 1'b0;
        alert_oen_o   <= 1'b1;
        seen_reg      <= {NKEY{1'b0}};
      end
      else if (!booted_reg)
      begin
        alert_cnt_reg <= alert_cnt_reg + 32'h1;
        if (alert_cnt_reg == ALERT_CYC - 1)
        begin
          booted_reg  <= 1'b1;
          alert_oen_o <= 1'b0;
        end
      end
      else if (det != seen_reg)
      begin
        alert_oen_o <= 1'b0;
        seen_reg    <= det;
      end
      else if (rd_ok && addr_i <= `TKD_A_KEYS_HI)
        alert_oen_o <= 1'b1;
    end

endmodule
`default_nettype wire
